// [wwt_top.sv]
`timescale 1ns/1ps
`include "wwt_cfg.svh"

module wwt_top import wwt_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   // supervised side
   input wire logic kick_input_i,
   input wire logic cfg_select_0_i,
   input wire logic cfg_select_1_i,
   input wire logic [1:0] timeout_cfg_pin_i,
   input wire logic [1:0] delay_cfg_pin_i,
   // open-drain fault pin: line level, drive value, enable (low drives)
   input wire logic fault_out_n_i,
   output logic fault_out_n_o,
   output logic fault_out_n_oe_n_o
);

   wwt_regs_t r_q;
   wwt_regs_t r_d;

   logic [1:0] sel;
   logic disabled;
   logic [31:0] upper;
   logic [31:0] lower;
   logic [31:0] delay;
   logic [31:0] limit;
   logic [4:0] shift;
   logic kick_fall;
   logic tmr_clear;
   logic [31:0] tmr_count;
   logic tmr_early;
   logic tmr_expired;
   logic [2:0] events;
   logic [2:0] w1c;
   logic access;
   logic complete;
   logic mapped;
   logic [31:0] rdata;
   logic [31:0] state_word;

   // strap decode shared by the timeout and delay pins;
   // the unused code 2'h3 falls back to the open preset
   function automatic logic [31:0] pin_time(
      input logic [1:0] pin,
      input logic [31:0] cap_cyc,
      input logic [31:0] pu_cyc,
      input logic [31:0] nc_cyc
   );
      logic [31:0] t;
      t = nc_cyc;
      if (pin == WWT_PIN_CAP) begin
         t = cap_cyc;
      end else if (pin == WWT_PIN_PULLUP) begin
         t = pu_cyc;
      end
      return t;
   endfunction

   // word address match for the register decode
   function automatic logic reg_hit(
      input logic [11:0] addr,
      input logic [11:0] off
   );
      return addr[11:2] == off[11:2];
   endfunction

   // select pins pick the window ratio or the disabled setting
   assign sel = {cfg_select_1_i, cfg_select_0_i};
   assign disabled = (sel == `WWT_SEL_OFF);

   // lower bound as a fraction of the upper bound, per select code
   always_comb begin
      shift = `WWT_SHIFT_00;
      unique case (sel)
         2'h0: shift = `WWT_SHIFT_00;
         2'h1: shift = `WWT_SHIFT_01;
         2'h2: shift = `WWT_SHIFT_00;
         2'h3: shift = `WWT_SHIFT_11;
      endcase
   end

   // capacitor value is held in software-set cycle counts
   assign upper = pin_time(timeout_cfg_pin_i, r_q.cap_upper,
                           32'(`WWT_UP_PU_CYC), 32'(`WWT_UP_NC_CYC));
   assign lower = upper >> shift;
   assign delay = pin_time(delay_cfg_pin_i, r_q.cap_delay,
                           32'(`WWT_RST_PU_CYC), 32'(`WWT_RST_NC_CYC));

   // one timer serves the window and the delay; only one runs at a time
   assign limit = (r_q.state == WWT_RUN) ? upper : delay;

   // inputs are synchronous, one stage is enough for the edge
   assign kick_fall = r_q.kick_prev & ~kick_input_i;

   wwt_window_timer u_timer (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clear_i(tmr_clear),
      .lower_i(lower),
      .upper_i(limit),
      .count_o(tmr_count),
      .early_o(tmr_early),
      .expired_o(tmr_expired)
   );

   // apb phases: one wait cycle, answer with pready in the next
   assign access = psel_i & penable_i;
   assign complete = access & r_q.pready;
   assign mapped = reg_hit(paddr_i, `WWT_OFF_STATUS) |
                   reg_hit(paddr_i, `WWT_OFF_MASK) |
                   reg_hit(paddr_i, `WWT_OFF_STATE) |
                   reg_hit(paddr_i, `WWT_OFF_CAP_UPPER) |
                   reg_hit(paddr_i, `WWT_OFF_CAP_DELAY) |
                   reg_hit(paddr_i, `WWT_OFF_COUNT);

   // write-one-to-clear strobe for the sticky events
   assign w1c = (complete & pwrite_i & reg_hit(paddr_i, `WWT_OFF_STATUS)) ?
                pwdata_i[2:0] : 3'h0;

   // live state snapshot for the read-only state word
   always_comb begin
      state_word = 32'h0000_0000;
      state_word[`WWT_ST_DISABLED] = disabled;
      state_word[`WWT_ST_FAULT] = (r_q.state == WWT_FAULT);
      state_word[`WWT_ST_INIT] = (r_q.state == WWT_INIT);
      state_word[`WWT_ST_LINE] = fault_out_n_i;
      state_word[`WWT_ST_SEL_LO] = sel[0];
      state_word[`WWT_ST_SEL_HI] = sel[1];
      state_word[`WWT_ST_OFF] = (r_q.state == WWT_OFF);
   end

   // read mux; unused bits read as zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (reg_hit(paddr_i, `WWT_OFF_STATUS)) begin
         rdata[2:0] = r_q.status;
      end else if (reg_hit(paddr_i, `WWT_OFF_MASK)) begin
         rdata[2:0] = r_q.mask;
      end else if (reg_hit(paddr_i, `WWT_OFF_STATE)) begin
         rdata = state_word;
      end else if (reg_hit(paddr_i, `WWT_OFF_CAP_UPPER)) begin
         rdata = r_q.cap_upper;
      end else if (reg_hit(paddr_i, `WWT_OFF_CAP_DELAY)) begin
         rdata = r_q.cap_delay;
      end else if (reg_hit(paddr_i, `WWT_OFF_COUNT)) begin
         rdata = tmr_count;
      end
   end

   // supervisor, bus slave and interrupt in one next-state process
   always_comb begin
      r_d = r_q;
      tmr_clear = 1'b0;
      events = 3'h0;
      r_d.kick_prev = kick_input_i;

      unique case (r_q.state)
         // power-up delay: kicks are not even looked at here
         WWT_INIT: begin
            if (disabled) begin
               r_d.state = WWT_OFF;
               tmr_clear = 1'b1;
            end else if (tmr_expired) begin
               r_d.state = WWT_RUN;
               tmr_clear = 1'b1;
            end
         end
         // window running: a kick on the last cycle still counts
         WWT_RUN: begin
            if (disabled) begin
               r_d.state = WWT_OFF;
               tmr_clear = 1'b1;
            end else if (kick_fall) begin
               tmr_clear = 1'b1;
               if (tmr_early) begin
                  r_d.state = WWT_FAULT;
                  events[`WWT_EV_EARLY] = 1'b1;
               end else begin
                  events[`WWT_EV_KICK] = 1'b1;
               end
            end else if (tmr_expired) begin
               r_d.state = WWT_FAULT;
               tmr_clear = 1'b1;
               events[`WWT_EV_LATE] = 1'b1;
            end
         end
         // fault held: kicks ignored until the delay has run out
         WWT_FAULT: begin
            if (disabled) begin
               r_d.state = WWT_OFF;
               tmr_clear = 1'b1;
            end else if (tmr_expired) begin
               r_d.state = WWT_RUN;
               tmr_clear = 1'b1;
            end
         end
         // disabled: the kick level has no effect at all
         WWT_OFF: begin
            if (!disabled) begin
               r_d.state = WWT_RUN;
               tmr_clear = 1'b1;
            end
         end
         default: begin
            r_d.state = WWT_INIT;
            tmr_clear = 1'b1;
         end
      endcase

      // pin pulled low only in the fault state; never driven high
      r_d.fault_oe_n = (r_d.state != WWT_FAULT);
      r_d.fault_out = 1'b0;

      // bus: first access cycle loads read data and error, next answers
      r_d.pready = access & ~r_q.pready;
      if (access & ~r_q.pready) begin
         r_d.pslverr = ~mapped;
         r_d.prdata = pwrite_i ? 32'h0000_0000 : rdata;
      end

      // writes take effect at the edge that completes the transfer
      if (complete & pwrite_i) begin
         if (reg_hit(paddr_i, `WWT_OFF_MASK)) begin
            r_d.mask = pwdata_i[2:0];
         end
         if (reg_hit(paddr_i, `WWT_OFF_CAP_UPPER)) begin
            r_d.cap_upper = pwdata_i;
         end
         if (reg_hit(paddr_i, `WWT_OFF_CAP_DELAY)) begin
            r_d.cap_delay = pwdata_i;
         end
      end

      // sticky events; a new event beats a clear in the same cycle
      r_d.status = (r_q.status & ~w1c) | events;

      // level interrupt from unmasked sticky bits
      r_d.irq = |(r_d.status & r_d.mask);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         r_q.state <= WWT_INIT;
         r_q.kick_prev <= 1'b1;
         r_q.status <= 3'h0;
         r_q.mask <= `WWT_MASK_RST;
         r_q.cap_upper <= `WWT_CAP_UP_RST;
         r_q.cap_delay <= `WWT_CAP_DLY_RST;
         r_q.pready <= 1'b0;
         r_q.pslverr <= 1'b0;
         r_q.prdata <= 32'h0000_0000;
         r_q.irq <= 1'b0;
         r_q.fault_oe_n <= 1'b1;
         r_q.fault_out <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // every output straight from the state flops
   assign prdata_o = r_q.prdata;
   assign pready_o = r_q.pready;
   assign pslverr_o = r_q.pslverr;
   assign irq_o = r_q.irq;
   assign fault_out_n_o = r_q.fault_out;
   assign fault_out_n_oe_n_o = r_q.fault_oe_n;

endmodule // wwt_top

// [wwt_cfg.svh]
`ifndef WWT_CFG_SVH
`define WWT_CFG_SVH

// clock rate in MHz, used to turn preset times into cycle counts
`define WWT_CLK_MHZ 25

// register byte offsets, one aligned 32-bit word each
`define WWT_ADDR_W 12
`define WWT_OFF_STATUS 12'h000
`define WWT_OFF_MASK 12'h004
`define WWT_OFF_STATE 12'h008
`define WWT_OFF_CAP_UPPER 12'h00C
`define WWT_OFF_CAP_DELAY 12'h010
`define WWT_OFF_COUNT 12'h014

// event bit positions in status and mask
`define WWT_EV_W 3
`define WWT_EV_EARLY 0
`define WWT_EV_LATE 1
`define WWT_EV_KICK 2

// state register field positions
`define WWT_ST_DISABLED 0
`define WWT_ST_FAULT 1
`define WWT_ST_INIT 2
`define WWT_ST_LINE 3
`define WWT_ST_SEL_LO 4
`define WWT_ST_SEL_HI 5
`define WWT_ST_OFF 6

// reset values
`define WWT_MASK_RST 3'h0
`define WWT_CAP_UP_RST 32'h0000_0800
`define WWT_CAP_DLY_RST 32'h0000_0200

// select codes: disabled code and lower-bound shifts (lower = upper >> shift)
`define WWT_SEL_OFF 2'h2
`define WWT_SHIFT_00 5'h03
`define WWT_SHIFT_01 5'h02
`define WWT_SHIFT_11 5'h01

// factory preset times in microseconds and their cycle counts
`define WWT_UP_PU_US 120
`define WWT_UP_NC_US 160
`define WWT_RST_PU_US 40
`define WWT_RST_NC_US 80
`define WWT_UP_PU_CYC (`WWT_UP_PU_US * `WWT_CLK_MHZ)
`define WWT_UP_NC_CYC (`WWT_UP_NC_US * `WWT_CLK_MHZ)
`define WWT_RST_PU_CYC (`WWT_RST_PU_US * `WWT_CLK_MHZ)
`define WWT_RST_NC_CYC (`WWT_RST_NC_US * `WWT_CLK_MHZ)

`endif

// [wwt_pkg.sv]
package wwt_pkg;

   // supervisor states, one-hot
   typedef enum logic [3:0] {
      WWT_INIT = 4'b0001,
      WWT_RUN = 4'b0010,
      WWT_FAULT = 4'b0100,
      WWT_OFF = 4'b1000
   } wwt_state_t;

   // strap seen on a timing configuration pin
   typedef enum logic [1:0] {
      WWT_PIN_CAP = 2'h0,
      WWT_PIN_PULLUP = 2'h1,
      WWT_PIN_OPEN = 2'h2
   } wwt_pin_t;

   // whole state of the top module
   typedef struct packed {
      wwt_state_t state;
      logic kick_prev;
      logic [2:0] status;
      logic [2:0] mask;
      logic [31:0] cap_upper;
      logic [31:0] cap_delay;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic fault_oe_n;
      logic fault_out;
   } wwt_regs_t;

   // whole state of the interval timer
   typedef struct packed {
      logic [31:0] cnt;
   } wwt_tmr_t;

endpackage

// [wwt_window_timer.sv]
`timescale 1ns/1ps

module wwt_window_timer import wwt_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic [31:0] lower_i,
   input wire logic [31:0] upper_i,
   output logic [31:0] count_o,
   output logic early_o,
   output logic expired_o
);

   wwt_tmr_t t_q;
   wwt_tmr_t t_d;
   logic [31:0] limit;

   // count cycles since the last clear; saturate so a stuck state never wraps
   always_comb begin
      t_d = t_q;
      if (clear_i) begin
         t_d.cnt = 32'h0000_0000;
      end else if (t_q.cnt != 32'hFFFF_FFFF) begin
         t_d.cnt = t_q.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   // a zero limit would never expire, so it is treated as one cycle
   assign limit = (upper_i == 32'h0000_0000) ? 32'h0000_0001 : upper_i;
   assign count_o = t_q.cnt;
   assign early_o = t_q.cnt < lower_i;
   assign expired_o = t_q.cnt >= (limit - 32'h0000_0001);

endmodule // wwt_window_timer

// [wwt_top_assertions.sv]
`timescale 1ns/1ps
module wwt_top_assertions #(parameter int DLY = 24) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic cfg_select_0_i,
   input wire logic cfg_select_1_i,
   input wire logic [1:0] delay_cfg_pin_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe_n_o
);
   logic [31:0] lo_q;
   logic off;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // disabled select code
   assign off = cfg_select_1_i && !cfg_select_0_i;
   // cycles the pin has been pulled low, so the pulse length is seen whole
   always_ff @(posedge sys_clk_i) begin
      lo_q <= (rst_i || fault_out_n_oe_n_o) ? 32'h0 : lo_q + 32'h1;
   end
   fault_drive_a: assert property (fault_out_n_o == 1'b0)
      else $error("fault pin driven high");
   off_release_a: assert property (off ##1 off |=> fault_out_n_oe_n_o)
      else $error("pin low while disabled");
   off_entry_a: assert property ($fell(fault_out_n_oe_n_o) |-> !$past(off))
      else $error("fault started while disabled");
   fault_len_a: assert property ($rose(fault_out_n_oe_n_o) && !$past(rst_i) && !$past(off)
      && $past(delay_cfg_pin_i) == 2'h0 |-> lo_q == DLY) else $error("fault pulse length wrong");
   fault_max_a: assert property (delay_cfg_pin_i == 2'h0 |-> lo_q <= DLY)
      else $error("fault pulse stretched");
   init_release_a: assert property ($fell(rst_i) |-> fault_out_n_oe_n_o [*8])
      else $error("pin low in power-up delay");
   pready_pulse_a: assert property (pready_o |=> !pready_o) // one-cycle answer
      else $error("pready longer than a cycle");
   rdata_hold_a: assert property (!$past(psel_i && penable_i) && !$past(rst_i) |-> $stable(prdata_o)) // held data
      else $error("read data changed outside transfer");
endmodule // wwt_top_assertions

// [wwt_host_model.sv]
`timescale 1ns/1ps
// supervised controller side: kick line and the pulled-up fault wire
module wwt_host_model (
   input wire logic kick_lvl_i,
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe_n_o,
   output logic kick_o,
   output logic fault_line_o
);
   // kick is never left floating, also with the watchdog off
   assign kick_o = (kick_lvl_i !== 1'b0);
   // pull-up gives the high level; the block only sinks
   assign fault_line_o = fault_out_n_oe_n_o ? 1'b1 : fault_out_n_o;
endmodule // wwt_host_model

// [window_watchdog_timer_test.sv]
`timescale 1ns/1ps
`include "wwt_cfg.svh"
module window_watchdog_timer_test import wwt_pkg::*;;
   typedef struct packed {logic [1:0] tp; logic [1:0] sel; logic [15:0] n; logic kk; logic [2:0] st;} wwt_row_t;
   // cap upper 40: lower 5/10/20; presets 3000 and 4000
   localparam wwt_row_t rows[13] = '{'{2'h0, 2'h0, 16'h1, 1'b1, 3'h1}, '{2'h0, 2'h0, 16'h6, 1'b1, 3'h4},
      '{2'h0, 2'h0, 16'h23, 1'b1, 3'h4}, '{2'h0, 2'h1, 16'h6, 1'b1, 3'h1}, '{2'h0, 2'h1, 16'hb, 1'b1, 3'h4},
      '{2'h0, 2'h3, 16'h10, 1'b1, 3'h1}, '{2'h0, 2'h3, 16'h15, 1'b1, 3'h4}, '{2'h0, 2'h1, 16'h2b, 1'b0, 3'h2},
      '{2'h1, 2'h0, 16'h173, 1'b1, 3'h1}, '{2'h1, 2'h0, 16'h17c, 1'b1, 3'h4}, '{2'h2, 2'h0, 16'h1f6, 1'b1, 3'h4},
      '{2'h2, 2'h0, 16'hf9b, 1'b1, 3'h4}, '{2'h1, 2'h0, 16'hbbb, 1'b0, 3'h2}};
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, kick_lvl = 1, kick, s0 = 0, s1 = 0, line, err;
   logic [1:0] tpin = 0, dpin = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, d;
   logic pready, pslverr, irq, fo, foe;
   logic [2:0] msk = 0;
   int fails = 0, num_checks = 0, cnt, i;
   always #20 clk = ~clk;
   wwt_top u_dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .kick_input_i(kick), .cfg_select_0_i(s0), .cfg_select_1_i(s1), .timeout_cfg_pin_i(tpin),
      .delay_cfg_pin_i(dpin), .fault_out_n_i(line), .fault_out_n_o(fo), .fault_out_n_oe_n_o(foe));
   wwt_host_model u_host (.kick_lvl_i(kick_lvl), .fault_out_n_o(fo), .fault_out_n_oe_n_o(foe), .kick_o(kick),
      .fault_line_o(line));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         fails++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one apb transfer, entered and left at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      psel <= 1;
      pen <= 0;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic wait_oe(input logic v);
      for (cnt = 0; cnt < 9000 && foe !== v; cnt++) @(posedge clk);
      check(foe, v);
   endtask
   task automatic kick_pulse(input logic [15:0] n);
      repeat (n) @(posedge clk);
      kick_lvl <= 0;
      repeat (2) @(posedge clk);
      kick_lvl <= 1;
   endtask
   // window start from a fault release; kicks chatter while the pin is low
   task automatic sync();
      wait_oe(0);
      apb(1, 12'h000, 32'h7, d);
      repeat (6) begin
         kick_lvl <= ~kick_lvl;
         @(posedge clk);
      end
      wait_oe(1);
   endtask
   task automatic run_row(input wwt_row_t r);
      tpin <= r.tp;
      s0 <= r.sel[0];
      s1 <= r.sel[1];
      sync();
      if (r.kk) kick_pulse(r.n);
      else repeat (r.n) @(posedge clk);
      apb(0, 12'h000, 32'h0, d);
      check(d, r.st);
      check(foe, r.st == 3'h4);
      check(irq, |(r.st & msk));
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      check({pready, irq, foe}, 3'h1);
      apb(0, 12'h004, 32'h0, d);
      check(d, 32'h0);
      apb(0, 12'h00C, 32'h0, d);
      check(d, 32'h0000_0800);
      apb(0, 12'h010, 32'h0, d);
      check(d, 32'h0000_0200);
      apb(0, 12'h020, 32'h0, d);
      check(err, 1'b1);
      kick_pulse(3);
      kick_pulse(3);
      apb(0, 12'h008, 32'h0, d);
      check(d[2], 1'b1);
      apb(0, 12'h000, 32'h0, d);
      check(d, 32'h0);
      apb(1, 12'h00C, 32'h28, d);
      apb(1, 12'h010, 32'h18, d);
      apb(1, 12'h004, 32'h7, d);
      msk = 3'h7;
      $display("init test done");
      for (i = 0; i < 13; i++) run_row(rows[i]);
      // only the late event may interrupt now
      apb(1, 12'h004, 32'h2, d);
      msk = 3'h2;
      run_row(rows[0]);
      $display("window rows done");
      tpin <= 0;
      s0 <= 0;
      s1 <= 0;
      sync();
      repeat (3) kick_pulse(16'h14);
      apb(0, 12'h000, 32'h0, d);
      check(d, 32'h4);
      check(foe, 1'b1);
      // preset delays, counted at the pin
      for (i = 1; i < 3; i++) begin
         dpin <= i[1:0];
         wait_oe(0);
         for (cnt = 0; cnt < 5000 && foe !== 1'b1; cnt++) @(posedge clk);
         check(cnt, i == 1 ? `WWT_RST_PU_CYC : `WWT_RST_NC_CYC);
      end
      dpin <= 0;
      s1 <= 1;
      repeat (3) @(posedge clk);
      apb(1, 12'h000, 32'h7, d);
      repeat (20) kick_pulse(16'h1);
      check(foe, 1'b1);
      apb(0, 12'h008, 32'h0, d);
      check(d[0], 1'b1);
      apb(0, 12'h000, 32'h0, d);
      check(d, 32'h0);
      check(irq, 1'b0);
      $display("disable test done");
      // reset in mid-run: back to the power-up delay with reset values
      s1 <= 0;
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      check(foe, 1'b1);
      apb(0, 12'h008, 32'h0, d);
      check(d[2], 1'b1);
      apb(0, 12'h010, 32'h0, d);
      check(d, `WWT_CAP_DLY_RST);
      $display("reset test done");
      wrap_up();
   end
   // about two and a half times the ~23k cycles the sequence needs, well inside the run budget
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      wrap_up();
   end
endmodule // window_watchdog_timer_test
bind wwt_top wwt_top_assertions #(.DLY(24)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .cfg_select_0_i(cfg_select_0_i), .cfg_select_1_i(cfg_select_1_i),
   .delay_cfg_pin_i(delay_cfg_pin_i), .prdata_o(prdata_o), .pready_o(pready_o), .fault_out_n_o(fault_out_n_o),
   .fault_out_n_oe_n_o(fault_out_n_oe_n_o));
